// ### cpsw_top.sv
/*
  Crosspoint switch state: serial slave on the link clock, staging
  and active switch sets on the system clock, readback of one row.
  Assumes the serial clock pin is the link clock, the data pin is
  wired open drain with a pull-up, and address pins are straps.
*/
// Overview of operation
// - address bits 0..2 come from the three select pins, in order
// - data pin is only released or pulled low, pull-up gives high
// - serial clock is input only and clocks data into the device
// - reset low keeps every switch open and registers cleared
// - eighty switch states, one per row and column pairing
// - power-up leaves all switches off and zeros until a write
// - master can read back on or off state of switches
// - many staged settings can be applied in one update
// - load flag one applies staging after the word, zero stages only
// - word bit fifteen one closes, zero opens, the addressed switch
// - upper four address bits fixed at binary 1110
`timescale 1ns/1ps
`default_nettype none

module cpsw_top
  import cpsw_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic scl_clk,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input wire logic addr_select_bit0,
  input wire logic addr_select_bit1,
  input wire logic addr_select_bit2,
  output logic [CPSW_NSW-1:0] switch_closed
);

  // ****************************************************************
  // link domain declarations
  // ****************************************************************
  cpsw_lstate_t st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic hi_r, hi_nxt;
  logic [7:0] word_hi_r, word_hi_nxt;
  cpsw_word_t word_r, word_nxt;
  logic word_tgl_r, word_tgl_nxt;
  logic start_seen_r, start_seen_nxt;
  logic [7:0] rd_byte_r, rd_byte_nxt;
  logic drv_r, drv_nxt;
  logic start_tgl;
  logic start_pend;
  logic [2:0] pins_s;
  logic [7:0] rb_s;
  logic [7:0] byte_in;
  logic match;

  // ****************************************************************
  // system domain declarations
  // ****************************************************************
  logic [CPSW_NSW-1:0] stage_r, stage_nxt;
  logic [CPSW_NSW-1:0] act_r, act_nxt;
  logic [3:0] last_row_r, last_row_nxt;
  logic [7:0] rb_byte_r, rb_byte_nxt;
  logic tgl_d_r, tgl_d_nxt;
  logic tgl_s;
  logic word_evt;

  // ****************************************************************
  // crossings and start detection
  // ****************************************************************
  cpsw_start_det u_start (
    .rstn(rstn),
    .sda_i(sda_i),
    .scl_i(scl_clk),
    .start_tgl(start_tgl)
  );

  // straps are static, two link clocks of settling is plenty
  cpsw_sync #(.W(3)) u_pins_sync (
    .clk(scl_clk),
    .rstn(rstn),
    .d({addr_select_bit2, addr_select_bit1, addr_select_bit0}),
    .q(pins_s)
  );

  // readback byte only moves after a word, long before a read uses it
  cpsw_sync #(.W(8)) u_rb_sync (
    .clk(scl_clk),
    .rstn(rstn),
    .d(rb_byte_r),
    .q(rb_s)
  );

  cpsw_sync #(.W(1)) u_word_sync (
    .clk(mclk),
    .rstn(rstn),
    .d(word_tgl_r),
    .q(tgl_s)
  );

  // ****************************************************************
  // link receive and state machine
  // ****************************************************************
  // start must act on the very next clock, so its toggle is compared
  // directly; it settles a full setup time before that edge
  assign start_pend = start_tgl ^ start_seen_r;
  assign byte_in = {shift_r[6:0], sda_i};
  // address byte sits whole in the shifter during the ack clock
  assign match = (shift_r[7:1] == {CPSW_ADDR_HI, pins_s});

  // next values of the link side, sampled on rising serial clock
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    hi_nxt = hi_r;
    word_hi_nxt = word_hi_r;
    word_nxt = word_r;
    word_tgl_nxt = word_tgl_r;
    start_seen_nxt = start_seen_r;
    rd_byte_nxt = rd_byte_r;
    if (start_pend) begin
      // first address bit arrives on the clock after the start
      st_nxt = CPSW_ADDR;
      cnt_nxt = 4'h1;
      shift_nxt = {7'h00, sda_i};
      hi_nxt = 1'b0;
      start_seen_nxt = start_tgl;
    end else if (cnt_r == CPSW_ACK_CNT) begin
      cnt_nxt = 4'h0;
      unique case (st_r)
        CPSW_ADDR: begin
          if (!match) begin
            st_nxt = CPSW_SKIP;
          end else if (shift_r[0]) begin
            st_nxt = CPSW_RDATA;
            rd_byte_nxt = rb_s;
          end else begin
            st_nxt = CPSW_WDATA;
          end
        end
        CPSW_RDATA: begin
          // master not acknowledging ends the read
          if (sda_i) begin
            st_nxt = CPSW_SKIP;
          end
        end
        CPSW_WDATA: begin
          st_nxt = CPSW_WDATA;
        end
        CPSW_SKIP: begin
          st_nxt = CPSW_SKIP;
        end
      endcase
    end else begin
      cnt_nxt = cnt_r + 4'h1;
      shift_nxt = byte_in;
      if (cnt_r == CPSW_LAST_BIT && st_r == CPSW_WDATA) begin
        if (!hi_r) begin
          word_hi_nxt = byte_in;
          hi_nxt = 1'b1;
        end else begin
          // word stays frozen until the next pair of bytes
          word_nxt = {word_hi_r, byte_in};
          word_tgl_nxt = ~word_tgl_r;
          hi_nxt = 1'b0;
        end
      end
    end
  end

  // link state registers
  always_ff @(posedge scl_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= CPSW_SKIP;
      cnt_r <= 4'h0;
      shift_r <= CPSW_BYTE_RST;
      hi_r <= 1'b0;
      word_hi_r <= CPSW_BYTE_RST;
      word_r <= CPSW_WORD_RST;
      word_tgl_r <= 1'b0;
      start_seen_r <= 1'b0;
      rd_byte_r <= CPSW_BYTE_RST;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      hi_r <= hi_nxt;
      word_hi_r <= word_hi_nxt;
      word_r <= word_nxt;
      word_tgl_r <= word_tgl_nxt;
      start_seen_r <= start_seen_nxt;
      rd_byte_r <= rd_byte_nxt;
    end
  end

  // ****************************************************************
  // link transmit: ack and read data change on falling clock
  // ****************************************************************
  always_comb begin
    drv_nxt = 1'b0;
    if (start_pend) begin
      drv_nxt = 1'b0;
    end else if (cnt_r == CPSW_ACK_CNT) begin
      drv_nxt = (st_r == CPSW_WDATA) || (st_r == CPSW_ADDR && match);
    end else if (st_r == CPSW_RDATA) begin
      drv_nxt = ~rd_byte_r[3'(CPSW_LAST_BIT - cnt_r)];
    end
  end

  // same link domain, opposite edge, so data is stable while clock high
  always_ff @(negedge scl_clk or negedge rstn) begin
    if (!rstn) begin
      drv_r <= 1'b0;
    end else begin
      drv_r <= drv_nxt;
    end
  end

  // open drain: never drive high, enable is low while pulling low
  assign sda_o = 1'b0;
  assign sda_oe_n = ~drv_r;

  // ****************************************************************
  // system side: staging and active sets
  // ****************************************************************
  // word is held stable by the link until the next word, so the
  // synchronised toggle qualifies it safely
  assign word_evt = tgl_s ^ tgl_d_r;

  always_comb begin
    stage_nxt = stage_r;
    act_nxt = act_r;
    last_row_nxt = last_row_r;
    tgl_d_nxt = tgl_s;
    // unknown row codes are ignored rather than aliased
    if (word_evt && word_r.row < CPSW_ROW_LIMIT) begin
      stage_nxt[{word_r.row, word_r.col}] = word_r.on;
      last_row_nxt = word_r.row;
    end
    if (word_evt && word_r.simultaneous_load_flag) begin
      act_nxt = stage_nxt;
    end
    rb_byte_nxt = act_r[{last_row_r, 3'b000} +: CPSW_COLS];
  end

  // reset also stands for power-on; reset is assumed high during writes
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      stage_r <= CPSW_SW_RST;
      act_r <= CPSW_SW_RST;
      last_row_r <= CPSW_ROW_RST;
      rb_byte_r <= CPSW_BYTE_RST;
      tgl_d_r <= 1'b0;
    end else begin
      stage_r <= stage_nxt;
      act_r <= act_nxt;
      last_row_r <= last_row_nxt;
      rb_byte_r <= rb_byte_nxt;
      tgl_d_r <= tgl_d_nxt;
    end
  end

  assign switch_closed = act_r;

  // ****************************************************************
  // assertions
  // ****************************************************************
  chk_addr_decode: assert property (@(posedge scl_clk) disable iff (!rstn)
    (!start_pend && cnt_r == CPSW_ACK_CNT && st_r == CPSW_ADDR)
      |=> ((st_r != CPSW_SKIP) == $past(match)))
    else $error("address decode wrong");

  chk_word_toggle: assert property (@(posedge scl_clk) disable iff (!rstn)
    (!start_pend && cnt_r == CPSW_LAST_BIT && st_r == CPSW_WDATA && hi_r)
      |=> (word_tgl_r != $past(word_tgl_r)))
    else $error("word not passed after second byte");

  chk_sda_drive: assert property (@(posedge scl_clk) disable iff (!rstn)
    !sda_oe_n |-> (sda_o == 1'b0 && (cnt_r == CPSW_ACK_CNT || st_r == CPSW_RDATA)))
    else $error("data pin driven outside ack or read");

  chk_reset_open: assert property (@(posedge mclk)
    !rstn |-> (switch_closed == CPSW_SW_RST && stage_r == CPSW_SW_RST))
    else $error("switches not open in reset");

  chk_stage_only: assert property (@(posedge mclk) disable iff (!rstn)
    !(word_evt && word_r.simultaneous_load_flag) |=> (act_r == $past(act_r)))
    else $error("active set moved without load");

  chk_load_copy: assert property (@(posedge mclk) disable iff (!rstn)
    (word_evt && word_r.simultaneous_load_flag) |=> (act_r == stage_r))
    else $error("load did not copy staging");

  chk_switch_bit: assert property (@(posedge mclk) disable iff (!rstn)
    (word_evt && word_r.row < CPSW_ROW_LIMIT)
      |=> (stage_r[{$past(word_r.row), $past(word_r.col)}] == $past(word_r.on)))
    else $error("staged switch bit wrong");

  chk_rb_row: assert property (@(posedge mclk) disable iff (!rstn)
    ##1 (rb_byte_r == $past(act_r[{last_row_r, 3'b000} +: CPSW_COLS])))
    else $error("readback byte wrong");

endmodule

`default_nettype wire

// ### cpsw_pkg.sv
/*
  Shared constants and types of the crosspoint switch state block:
  array size, slave address prefix, serial word layout, link states.
  Assumes nothing of its surroundings; imported by every design file.
*/
`default_nettype none

package cpsw_pkg;

  // ****************************************************************
  // array geometry
  // ****************************************************************
  localparam int CPSW_ROWS = 10;
  localparam int CPSW_COLS = 8;
  localparam int CPSW_NSW = 80;
  localparam logic [3:0] CPSW_ROW_LIMIT = 4'hA;

  // ****************************************************************
  // serial framing
  // ****************************************************************
  // fixed upper four bits of the 7-bit slave address
  localparam logic [3:0] CPSW_ADDR_HI = 4'hE;
  // bit counter value of the ninth (acknowledge) clock
  localparam logic [3:0] CPSW_ACK_CNT = 4'h8;
  // bit counter value of the last data bit of a byte
  localparam logic [3:0] CPSW_LAST_BIT = 4'h7;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [CPSW_NSW-1:0] CPSW_SW_RST = 80'h0;
  localparam logic [7:0] CPSW_BYTE_RST = 8'h00;
  localparam logic [3:0] CPSW_ROW_RST = 4'h0;

  // the two data bytes of one write word, high byte first
  typedef struct packed {
    logic on;
    logic [3:0] row;
    logic [2:0] col;
    logic [6:0] spare;
    logic simultaneous_load_flag;
  } cpsw_word_t;

  localparam cpsw_word_t CPSW_WORD_RST = 16'h0000;

  // link states, gray along idle-skip -> address -> write; address -> read flips both bits
  typedef enum logic [1:0] {
    CPSW_SKIP = 2'b10,
    CPSW_ADDR = 2'b00,
    CPSW_WDATA = 2'b01,
    CPSW_RDATA = 2'b11
  } cpsw_lstate_t;

endpackage

`default_nettype wire

// ### cpsw_sync.sv
/*
  Two-stage synchroniser for levels or slowly changing words.
  Assumes each bit of a word is stable for several destination
  clocks before it is used, so bits cannot tear.
*/
`timescale 1ns/1ps
`default_nettype none

module cpsw_sync
  import cpsw_pkg::*;
#(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  // ****************************************************************
  // two flops; only the second stage is looked at
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= d;
      q_r <= meta_r;
    end
  end

  assign q = q_r;

endmodule

`default_nettype wire

// ### cpsw_start_det.sv
/*
  Start condition detector: toggles its output on every falling
  data edge seen while the serial clock is high.
  Assumes the serial data pin is glitch filtered outside.
*/
`timescale 1ns/1ps
`default_nettype none

module cpsw_start_det
  import cpsw_pkg::*;
(
  input wire logic rstn,
  input wire logic sda_i,
  input wire logic scl_i,
  output logic start_tgl
);

  logic tgl_r;

  // ****************************************************************
  // data line used as clock; a toggle so no pulse is ever lost
  // ****************************************************************
  always_ff @(negedge sda_i or negedge rstn) begin
    if (!rstn) begin
      tgl_r <= 1'b0;
    end else if (scl_i) begin
      tgl_r <= ~tgl_r;
    end
  end

  assign start_tgl = tgl_r;

endmodule

`default_nettype wire

// ### cpsw_i2c_master.sv
/*
  Behavioural serial bus master for the crosspoint switch block:
  start, stop, byte out with acknowledge, byte in with acknowledge.
  Assumes the bench resolves the data wire from both pull enables
  and a pull-up.
*/
`timescale 1ns/1ps
`default_nettype none

module cpsw_i2c_master (
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  // ****************************************************************
  // bus phases, 32 ns per bit
  // ****************************************************************
  // clock idles high and stands still between frames
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // data moves mid low phase only, so no false start or stop
  task automatic pulse(input logic b, output logic s);
    #8 sda_pull = ~b;
    #8 scl = 1'b1;
    #1 s = sda;
    #15 scl = 1'b0;
  endtask

  task automatic start();
    #16 sda_pull = 1'b1;
    #16 scl = 1'b0;
  endtask

  task automatic stop();
    #8 sda_pull = 1'b1;
    #8 scl = 1'b1;
    #8 sda_pull = 1'b0;
    #16;
  endtask

  // msb first, then the ninth clock with the wire released
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      pulse(b[i], s);
    end
    pulse(1'b1, s);
    ack = ~s;
  endtask

  task automatic recv_byte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 0; i < 8; i++) begin
      pulse(1'b1, s);
      d = {d[6:0], s};
    end
    pulse(nack, s);
  endtask
endmodule

`default_nettype wire

// ### tb_top.sv
/*
  Self-checking bench of the crosspoint switch state block: table of
  single-word frames, then multi-word, address, and reset cases.
  Assumes the serial master model drives the link clock.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import cpsw_pkg::*;
();
  // ****************************************************************
  // signals and instances
  // ****************************************************************
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] pins = 3'b011; // {bit2, bit1, bit0}
  logic scl, sda_pull, sda_o, sda_oe_n, ack;
  wire logic sda;
  logic [CPSW_NSW-1:0] sw_closed;
  logic [CPSW_NSW-1:0] stg = '0;
  logic [CPSW_NSW-1:0] act = '0;
  logic [3:0] last_row = 4'h0;
  logic [7:0] rd0, rd1;
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;
  // word = {on, row, col, load}
  logic [8:0] rows [6] = '{9'h100, 9'h19E, 9'h13B, 9'h1A4, 9'h09F, 9'h10F};
  int closed [6] = '{0, 0, 3, 3, 2, 3};

  // open drain wire: low if anyone pulls, else the pull-up wins
  assign sda = (sda_pull || sda_oe_n === 1'b0) ? 1'b0 : 1'b1;

  always #12.5 mclk = ~mclk;

  cpsw_i2c_master u_m (.scl(scl), .sda_pull(sda_pull), .sda(sda));

  cpsw_top u_dut (
    .mclk(mclk), .rstn(rstn), .scl_clk(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .addr_select_bit0(pins[0]),
    .addr_select_bit1(pins[1]), .addr_select_bit2(pins[2]),
    .switch_closed(sw_closed)
  );

  // ****************************************************************
  // checking and reporting
  // ****************************************************************
  task automatic check(input logic ok, input string what);
    cmp_count++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("ERROR %0t: %s", $time, what);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // hang guard, generous against roughly 760 cycles of traffic
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      summarize();
    end
  end

  // ****************************************************************
  // frame helpers and reference model
  // ****************************************************************
  task automatic open_frame(input logic rw);
    u_m.start();
    u_m.send_byte({4'hE, pins, rw}, ack);
    check(ack === 1'b1, "own address not acked");
  endtask

  // odd don't-care bits in the low byte must not matter
  task automatic word(input logic [8:0] w);
    u_m.send_byte(w[8:1], ack);
    check(ack === 1'b1, "high byte not acked");
    u_m.send_byte({7'h55, w[0]}, ack);
    check(ack === 1'b1, "low byte not acked");
    if (w[7:4] < 4'hA) begin
      stg[{w[7:4], w[3:1]}] = w[8];
      last_row = w[7:4];
    end
    if (w[0]) begin
      act = stg;
    end
  endtask

  // transfer to the system clock takes 3 to 4 edges; 8 is safe
  task automatic settle();
    repeat (8) @(posedge mclk);
    check(sw_closed === act, "active switch set differs");
  endtask

  task automatic readback();
    open_frame(1'b1);
    u_m.recv_byte(1'b0, rd0);
    u_m.recv_byte(1'b1, rd1);
    u_m.stop();
    check(rd0 === act[{last_row, 3'h0} +: 8], "readback byte");
    check(rd1 === rd0, "repeated readback byte");
  endtask

  // a frame nobody claims still clocks the address synchronisers
  task automatic foreign(input logic [7:0] a);
    u_m.start();
    u_m.send_byte(a, ack);
    u_m.stop();
    check(ack === 1'b0, "foreign address acked");
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (4) @(posedge mclk);
    check(sw_closed === '0, "switches closed in reset");
    rstn <= 1'b1; // held high through every frame
    foreign(8'h00);
    check(sw_closed === '0, "switches closed after power-up");
    readback();
    $display("test power-up done");

    for (int i = 0; i < 6; i++) begin
      open_frame(1'b0);
      word(rows[i]);
      u_m.stop();
      settle();
      check($countones(sw_closed) == closed[i], "closed count");
      check(sda_oe_n === 1'b1, "data wire held after frame");
      if (rows[i][7:4] < 4'hA) begin
        readback();
      end
    end
    $display("test table done");

    // a lone high byte before stop must be dropped, or the next frame
    // would pair wrongly and its load bit would move the active set
    open_frame(1'b0);
    u_m.send_byte(8'hB8, ack);
    check(ack === 1'b1, "lone high byte not acked");
    u_m.stop();
    settle();

    // latched word must not show until the loading word of the frame
    open_frame(1'b0);
    word(9'h122);
    settle();
    word(9'h14D);
    u_m.stop();
    settle();
    $display("test multi-word done");

    foreign({4'hE, pins[0], pins[1], pins[2], 1'b0});
    foreign({4'h6, pins, 1'b0});
    $display("test address done");

    @(posedge mclk);
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    check(sw_closed === '0, "reset left switches closed");
    check(sda_oe_n === 1'b1, "data wire pulled in reset");
    check(sda_o === 1'b0, "data driver not low");
    pins <= 3'b100;
    rstn <= 1'b1;
    stg = '0;
    act = '0;
    last_row = 4'h0;
    foreign(8'h00);
    readback();
    open_frame(1'b0);
    word(9'h101);
    u_m.stop();
    settle();
    $display("test reset done");
    summarize();
  end
endmodule

`default_nettype wire
